// ---- hw/sim_uart_pkg.sv ----
// Constants for the smart-card mode of the serial channel.
// Assumes a 16-bit register port addressed by word index.
package sim_uart_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;
  // Register indices
  localparam logic [2:0] REG_TXBUF = 3'h0;
  localparam logic [2:0] REG_RXBUF = 3'h1;
  localparam logic [2:0] REG_BAUD  = 3'h2;
  localparam logic [2:0] REG_MODE  = 3'h3;
  localparam logic [2:0] REG_CTLA  = 3'h4;
  localparam logic [2:0] REG_CTLB  = 3'h5;
  localparam logic [2:0] REG_IRQ   = 3'h6;
  // serial_mode_reg fields
  localparam int MODE_SEL_LSB = 0;
  localparam int MODE_CLOCK_SOURCE_SELECT   = 3;
  localparam int MODE_PRY     = 5;
  localparam logic [2:0] MODE_SIM = 3'h5;
  // serial_control_a fields
  localparam int CTLA_SRC_LSB = 0;
  localparam int CTLA_SHIFT_REGISTER_EMPTY   = 3;
  localparam int CTLA_BIT_ORDER_SELECT   = 7;
  // serial_control_b fields
  localparam int CTLB_TE  = 0;
  localparam int CTLB_TI  = 1;
  localparam int CTLB_RE  = 2;
  localparam int CTLB_RI  = 3;
  localparam int CTLB_IRS = 4;
  localparam int CTLB_LCH = 6;
  localparam int CTLB_ERE = 7;
  // receive_buffer flag positions
  localparam int RB_OER = 12;
  localparam int RB_FER = 13;
  localparam int RB_PER = 14;
  localparam int RB_SUM = 15;
  // Interrupt request register bits
  localparam int IRQ_TX = 0;
  localparam int IRQ_RX = 1;
  // Bit timing, register reset value and frame states
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
  localparam logic [3:0] START_MID       = 4'h7;
  localparam logic [2:0] LAST_DATA_BIT   = 3'h7;
  localparam logic [7:0] REG_RESET       = 8'h00;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_START  = 3'b001,
    ST_DATA   = 3'b011,
    ST_PARITY = 3'b010,
    ST_STOP   = 3'b110
  } frame_state_e;
endpackage

// ---- hw/sim_uart.sv ----
// Smart-card mode of an asynchronous serial channel, one shared data line.
// Assumes a register master on the same clock and an external pull-up.
// What this block, its software and the board do
// R01: On overrun, buffer keeps the previous character and no new receive request is raised.
// R02: Transmit request appears after enabling sources, transmit, and writing data.
// R03: Framing and parity flags are latched when a character enters the buffer.
// R04: Software selects mode 101b and zeroes every unassigned configuration bit.
// R05: Bit rate is source clock divided by 16 times divider plus one.
// R06: Handshake selection is ignored; handshake pins stay disabled.
// R07: Parity error signal is produced only when error output is enabled.
// R08: A received parity error pulls the transmit pin low after the character.
// R09: Reading receive buffer during error signal clears parity flag and releases pin.
// R10: Transmit complete request is raised on the edge right after stop bit.
// R11: Software samples the receive pin in the transmit handler for card errors.
// R12: Direct format sends byte uninverted, D0 first, with even parity.
// R13: Direct format stores received bits uninverted from D0, checks even parity.
// R14: Inverse format sends inverted byte, D7 first, with odd parity.
// R15: Inverse format stores inverted bits from D7, checks odd parity.
// R16: Direct format software settings: parity on, even, LSB first, no inversion.
// R17: Inverse format software settings: parity on, odd, MSB first, inverted.
// R18: A high transmit bit is left floating on the external pull-up.
// R19: Board joins transmit and receive pins and fits a pull-up.
// R20: Error-sum flag is set on any overrun, framing or parity error.
// R21: Frame is start, eight data, parity, one stop; both ends share bit period.
`timescale 1ns/100ps
`default_nettype none
module sim_uart (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [2:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        writeStrobe,
  input  wire logic        readStrobe,
  output var  logic [15:0] rdata,
  input  wire logic        serialInPin,
  input  wire logic        externalClockPin,
  output var  logic        serialOutPinOut,
  output var  logic        serialOutPinOe,
  output var  logic        txIrqRequest,
  output var  logic        rxIrqRequest
);
  logic [1:0] rstPipe;
  logic       rstSync_n;
  logic [7:0] txBuf, baudDiv, modeReg, ctlA, ctlB;
  logic [7:0] rxData, txSh, rxSh;
  logic       txFull, rxFull, overrunFlag, framingFlag, parityFlag, errDrive;
  logic       txPar, rxPar;
  logic [4:0] prescale;
  logic [7:0] baudCnt;
  logic       tick16, srcTick;
  logic [1:0] extSync, inSync;
  logic       extPrev;
  logic [3:0] txSub, rxSub;
  logic [2:0] txIdx, rxIdx;
  sim_uart_pkg::frame_state_e txState, rxState;
  logic simMode, msbFirst, invert, evenPar, xfer, perrNow, txLevel, rbRead;
  logic txBitEnd, rxSample, txStart, txDone;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstSync_n = rstPipe[1];

  assign simMode  = modeReg[sim_uart_pkg::MODE_SEL_LSB +: 3] == sim_uart_pkg::MODE_SIM;
  assign msbFirst = ctlA[sim_uart_pkg::CTLA_BIT_ORDER_SELECT];
  assign invert   = ctlB[sim_uart_pkg::CTLB_LCH];
  assign evenPar  = modeReg[sim_uart_pkg::MODE_PRY];
  assign rbRead   = readStrobe && addr == sim_uart_pkg::REG_RXBUF;
  // Handshake fields are stored but drive nothing in this mode (see R06)

  // Pin inputs pass two flops before anything looks at them
  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      extSync <= 2'h0;
      extPrev <= 1'b0;
      inSync  <= 2'h3;
    end else begin
      extSync <= {extSync[0], externalClockPin};
      extPrev <= extSync[1];
      inSync  <= {inSync[0], serialInPin};
    end
  end

  // Count source: internal clock /1,/2,/8,/32 or rising edges of the pin (see R05)
  always_comb begin
    if (modeReg[sim_uart_pkg::MODE_CLOCK_SOURCE_SELECT]) begin
      srcTick = extSync[1] && !extPrev;
    end else begin
      unique case (ctlA[sim_uart_pkg::CTLA_SRC_LSB +: 2])
        2'h0: srcTick = 1'b1;
        2'h1: srcTick = prescale[0];
        2'h2: srcTick = &prescale[2:0];
        2'h3: srcTick = &prescale;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      prescale <= 5'h00;
      baudCnt  <= 8'h00;
      tick16   <= 1'b0;
    end else begin
      prescale <= prescale + 5'h01;
      tick16   <= 1'b0;
      if (srcTick) begin
        if (baudCnt >= baudDiv) begin // see R05
          baudCnt <= 8'h00;
          tick16  <= 1'b1;
        end else begin
          baudCnt <= baudCnt + 8'h01;
        end
      end
    end
  end

  // Transmitter
  assign txBitEnd = tick16 && txSub == sim_uart_pkg::OVERSAMPLE_LAST;
  assign txStart  = txState == sim_uart_pkg::ST_IDLE && tick16 && simMode
                    && ctlB[sim_uart_pkg::CTLB_TE] && txFull;
  assign txDone   = txState == sim_uart_pkg::ST_STOP && txBitEnd;

  always_comb begin
    unique case (txState)
      sim_uart_pkg::ST_START:  txLevel = 1'b0;
      sim_uart_pkg::ST_DATA:   txLevel = msbFirst ? txSh[7] : txSh[0]; // see R12 R14
      sim_uart_pkg::ST_PARITY: txLevel = txPar;
      default:                 txLevel = 1'b1;
    endcase
  end

  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      txState <= sim_uart_pkg::ST_IDLE;
      txSub   <= 4'h0;
      txIdx   <= 3'h0;
      txSh    <= 8'h00;
      txPar   <= 1'b0;
    end else begin
      if (tick16) begin
        txSub <= txSub + 4'h1;
      end
      unique case (txState)
        sim_uart_pkg::ST_IDLE: begin
          txSub <= 4'h0;
          if (txStart) begin
            txState <= sim_uart_pkg::ST_START;
            txSh    <= invert ? ~txBuf : txBuf; // see R12 R14
            // Inverting all eight bits keeps their parity, so only the polarity counts
            txPar   <= ^txBuf ^ !evenPar; // see R12 R14
          end
        end
        sim_uart_pkg::ST_START: begin
          if (txBitEnd) begin
            txState <= sim_uart_pkg::ST_DATA;
            txIdx   <= 3'h0;
          end
        end
        sim_uart_pkg::ST_DATA: begin
          if (txBitEnd) begin
            txSh  <= msbFirst ? {txSh[6:0], 1'b0} : {1'b0, txSh[7:1]};
            txIdx <= txIdx + 3'h1;
            if (txIdx == sim_uart_pkg::LAST_DATA_BIT) begin
              txState <= sim_uart_pkg::ST_PARITY;
            end
          end
        end
        sim_uart_pkg::ST_PARITY: begin
          if (txBitEnd) begin
            txState <= sim_uart_pkg::ST_STOP;
          end
        end
        sim_uart_pkg::ST_STOP: begin
          if (txBitEnd) begin // see R21
            txState <= sim_uart_pkg::ST_IDLE;
          end
        end
        default: txState <= sim_uart_pkg::ST_IDLE;
      endcase
    end
  end

  // Receiver, sampling mid-bit at 16x
  assign rxSample = tick16 && rxSub == sim_uart_pkg::OVERSAMPLE_LAST;
  assign xfer     = rxState == sim_uart_pkg::ST_STOP && rxSample;
  assign perrNow  = ^rxSh ^ rxPar ^ !evenPar; // see R13 R15

  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      rxState <= sim_uart_pkg::ST_IDLE;
      rxSub   <= 4'h0;
      rxIdx   <= 3'h0;
      rxSh    <= 8'h00;
      rxPar   <= 1'b0;
    end else begin
      if (tick16) begin
        rxSub <= rxSub + 4'h1;
      end
      unique case (rxState)
        sim_uart_pkg::ST_IDLE: begin
          rxSub <= 4'h0;
          // Our own error pulse is not a start bit; its synchronised tail fails the mid check
          if (tick16 && !inSync[1] && !errDrive && simMode
              && ctlB[sim_uart_pkg::CTLB_RE]) begin
            rxState <= sim_uart_pkg::ST_START;
          end
        end
        sim_uart_pkg::ST_START: begin
          if (tick16 && rxSub == sim_uart_pkg::START_MID) begin
            rxSub   <= 4'h0;
            rxIdx   <= 3'h0;
            rxState <= inSync[1] ? sim_uart_pkg::ST_IDLE : sim_uart_pkg::ST_DATA;
          end
        end
        sim_uart_pkg::ST_DATA: begin
          if (rxSample) begin // see R13 R15
            rxSh  <= msbFirst ? {rxSh[6:0], inSync[1]} : {inSync[1], rxSh[7:1]};
            rxIdx <= rxIdx + 3'h1;
            if (rxIdx == sim_uart_pkg::LAST_DATA_BIT) begin
              rxState <= sim_uart_pkg::ST_PARITY;
            end
          end
        end
        sim_uart_pkg::ST_PARITY: begin
          if (rxSample) begin
            rxPar   <= inSync[1];
            rxState <= sim_uart_pkg::ST_STOP;
          end
        end
        sim_uart_pkg::ST_STOP: begin
          if (rxSample) begin
            rxState <= sim_uart_pkg::ST_IDLE;
          end
        end
        default: rxState <= sim_uart_pkg::ST_IDLE;
      endcase
    end
  end

  // Receive buffer and error flags; a new event beats a same-cycle clear
  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      rxData      <= 8'h00;
      rxFull      <= 1'b0;
      overrunFlag <= 1'b0;
      framingFlag <= 1'b0;
      parityFlag  <= 1'b0;
      errDrive    <= 1'b0;
    end else begin
      if (rbRead) begin
        rxFull <= 1'b0;
        if (errDrive) begin // see R09
          parityFlag <= 1'b0;
          errDrive   <= 1'b0;
        end
      end
      if (xfer) begin
        framingFlag <= !inSync[1]; // see R03
        parityFlag  <= perrNow; // see R03
        errDrive    <= perrNow && ctlB[sim_uart_pkg::CTLB_ERE]; // see R07 R08
        if (rxFull && !rbRead) begin
          overrunFlag <= 1'b1; // see R01
        end else begin
          overrunFlag <= 1'b0;
          rxFull      <= 1'b1;
          rxData      <= invert ? ~rxSh : rxSh; // see R13 R15
        end
      end
    end
  end

  // Pin: only ever pulls low; a high level is left to the pull-up (see R18)
  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      serialOutPinOut <= 1'b0;
      serialOutPinOe  <= 1'b0;
    end else begin
      serialOutPinOut <= 1'b0;
      serialOutPinOe  <= !txLevel || errDrive; // see R08 R18
    end
  end

  // Software registers and interrupt requests
  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      txBuf        <= sim_uart_pkg::REG_RESET;
      baudDiv      <= sim_uart_pkg::REG_RESET;
      modeReg      <= sim_uart_pkg::REG_RESET;
      ctlA         <= sim_uart_pkg::REG_RESET;
      ctlB         <= sim_uart_pkg::REG_RESET;
      txFull       <= 1'b0;
      txIrqRequest <= 1'b0;
      rxIrqRequest <= 1'b0;
    end else begin
      if (writeStrobe) begin
        unique case (addr)
          sim_uart_pkg::REG_TXBUF: begin
            txBuf  <= wdata[7:0];
            txFull <= 1'b1;
          end
          sim_uart_pkg::REG_BAUD: baudDiv <= wdata[7:0];
          sim_uart_pkg::REG_MODE: modeReg <= wdata[7:0];
          sim_uart_pkg::REG_CTLA: ctlA    <= wdata[7:0];
          sim_uart_pkg::REG_CTLB: ctlB    <= wdata[7:0];
          sim_uart_pkg::REG_IRQ: begin
            if (wdata[sim_uart_pkg::IRQ_TX]) txIrqRequest <= 1'b0; // see R02
            if (wdata[sim_uart_pkg::IRQ_RX]) rxIrqRequest <= 1'b0;
          end
          default: ;
        endcase
      end
      if (txStart) begin
        txFull <= 1'b0;
      end
      if ((txStart && !ctlB[sim_uart_pkg::CTLB_IRS])
          || (txDone && ctlB[sim_uart_pkg::CTLB_IRS])) begin
        txIrqRequest <= 1'b1; // see R02 R10
      end
      if (xfer && !(rxFull && !rbRead)) begin
        rxIrqRequest <= 1'b1; // see R01
      end
    end
  end

  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= 16'h0000;
      if (readStrobe) begin
        unique case (addr)
          sim_uart_pkg::REG_TXBUF: rdata <= {8'h00, txBuf};
          sim_uart_pkg::REG_RXBUF: begin
            rdata[7:0]                 <= rxData;
            rdata[sim_uart_pkg::RB_OER] <= overrunFlag;
            rdata[sim_uart_pkg::RB_FER] <= framingFlag;
            rdata[sim_uart_pkg::RB_PER] <= parityFlag;
            rdata[sim_uart_pkg::RB_SUM] <= overrunFlag | framingFlag | parityFlag; // see R20
          end
          sim_uart_pkg::REG_BAUD: rdata <= {8'h00, baudDiv};
          sim_uart_pkg::REG_MODE: rdata <= {8'h00, modeReg};
          sim_uart_pkg::REG_CTLA: begin
            rdata[7:0] <= ctlA;
            rdata[sim_uart_pkg::CTLA_SHIFT_REGISTER_EMPTY] <= txState == sim_uart_pkg::ST_IDLE;
          end
          sim_uart_pkg::REG_CTLB: begin
            rdata[7:0] <= ctlB;
            rdata[sim_uart_pkg::CTLB_TI] <= !txFull;
            rdata[sim_uart_pkg::CTLB_RI] <= rxFull;
          end
          sim_uart_pkg::REG_IRQ: rdata <= {14'h0000, rxIrqRequest, txIrqRequest};
          default: ;
        endcase
      end
    end
  end

  // Checks
  sequence s_err_raised;
    xfer && perrNow && ctlB[sim_uart_pkg::CTLB_ERE];
  endsequence
  sequence s_err_driven;
    errDrive ##1 serialOutPinOe;
  endsequence
  property p_overrun_no_irq;
    @(posedge clock) disable iff (!rstSync_n)
    (xfer && rxFull && !rbRead && !rxIrqRequest) |=> !rxIrqRequest;
  endproperty
  a_overrun_no_irq: assert property (p_overrun_no_irq) else $error("irq on overrun"); // see R01
  property p_framing_latch;
    @(posedge clock) disable iff (!rstSync_n)
    xfer |=> framingFlag == !$past(inSync[1]);
  endproperty
  a_framing_latch: assert property (p_framing_latch) else $error("framing flag wrong"); // see R03
  property p_err_enable;
    @(posedge clock) disable iff (!rstSync_n)
    $rose(errDrive) |-> $past(ctlB[sim_uart_pkg::CTLB_ERE]);
  endproperty
  a_err_enable: assert property (p_err_enable) else $error("error signal disabled"); // see R07
  property p_err_drive;
    @(posedge clock) disable iff (!rstSync_n)
    s_err_raised |=> s_err_driven;
  endproperty
  a_err_drive: assert property (p_err_drive) else $error("error signal missing"); // see R08
  property p_err_release;
    @(posedge clock) disable iff (!rstSync_n)
    (rbRead && errDrive && !xfer) |=> !parityFlag && !errDrive;
  endproperty
  a_err_release: assert property (p_err_release) else $error("error not released"); // see R09
  property p_tx_done_irq;
    @(posedge clock) disable iff (!rstSync_n)
    (txDone && ctlB[sim_uart_pkg::CTLB_IRS]) |=> txIrqRequest;
  endproperty
  a_tx_done_irq: assert property (p_tx_done_irq) else $error("no tx irq"); // see R10
  property p_tx_pin;
    @(posedge clock) disable iff (!rstSync_n)
    (txState != sim_uart_pkg::ST_IDLE && !errDrive) |=> serialOutPinOe == !$past(txLevel);
  endproperty
  a_tx_pin: assert property (p_tx_pin) else $error("tx pin level wrong"); // see R12 R18
  property p_sum_flag;
    @(posedge clock) disable iff (!rstSync_n)
    (rbRead && (overrunFlag || parityFlag)) |=> rdata[sim_uart_pkg::RB_SUM];
  endproperty
  a_sum_flag: assert property (p_sum_flag) else $error("sum flag clear"); // see R20
endmodule
`default_nettype wire

// ---- verification/smart_card_model.sv ----
// Behavioural smart card on the shared, pulled-up data line.
// Assumes the bench resolves the line level from every open-drain enable.
`timescale 1ns/100ps
`default_nettype none
module smart_card_model (
  input  wire logic clock,
  input  wire logic line,
  output var  logic cardOe
);
  initial cardOe = 1'b0;

  // Start bit, then bits in send order; a 0 pulls low, a 1 is left to the pull-up
  task automatic sendFrame(input logic [9:0] bits, input int bitCyc);
    @(posedge clock);
    cardOe <= 1'b1;
    repeat (bitCyc) @(posedge clock);
    for (int i = 0; i < 10; i++) begin
      cardOe <= ~bits[i];
      repeat (bitCyc) @(posedge clock);
    end
    // Released even after a broken stop bit, so the line never sticks low
    cardOe <= 1'b0;
  endtask

  // Measures the start bit and samples each later bit at its middle
  task automatic recvFrame(output logic [9:0] bits, output int startLen,
                           input int bitCyc);
    int w;
    w = 0;
    bits = '1;
    startLen = 0;
    while (line === 1'b1 && w < 4000) begin
      @(negedge clock);
      w++;
    end
    while (line === 1'b0 && startLen < 4000) begin
      @(negedge clock);
      startLen++;
    end
    repeat (bitCyc / 2) @(negedge clock);
    bits[0] = line;
    for (int i = 1; i < 10; i++) begin
      repeat (bitCyc) @(negedge clock);
      bits[i] = line;
    end
  endtask
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the smart-card serial channel.
// Assumes one clock; the card model and the block share one pulled-up line.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [2:0]  addr = 3'h0;
  logic [15:0] wdata = 16'h0000;
  logic        writeStrobe = 1'b0;
  logic        readStrobe = 1'b0;
  logic [15:0] rdata;
  logic        serialOutPinOut;
  logic        serialOutPinOe;
  logic        txIrqRequest;
  logic        rxIrqRequest;
  logic        cardOe;
  wire logic   line;
  int          n_mismatch = 0;
  int          checks = 0;

  always #2 clock = ~clock;

  // Both pins tied to one wire; nobody pulling low means the pull-up wins
  assign line = ~(serialOutPinOe | cardOe);

  sim_uart dut (
    .clock           (clock),
    .rst_n           (rst_n),
    .addr            (addr),
    .wdata           (wdata),
    .writeStrobe     (writeStrobe),
    .readStrobe      (readStrobe),
    .rdata           (rdata),
    .serialInPin     (line),
    .externalClockPin(1'b0),
    .serialOutPinOut (serialOutPinOut),
    .serialOutPinOe  (serialOutPinOe),
    .txIrqRequest    (txIrqRequest),
    .rxIrqRequest    (rxIrqRequest)
  );

  smart_card_model card (
    .clock (clock),
    .line  (line),
    .cardOe(cardOe)
  );

  task automatic print_verdict();
    if (n_mismatch == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmpBit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic regWrite(input logic [2:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    writeStrobe <= 1'b1;
    @(posedge clock);
    writeStrobe <= 1'b0;
  endtask

  task automatic regRead(input logic [2:0] a, output logic [15:0] d);
    @(posedge clock);
    addr <= a;
    readStrobe <= 1'b1;
    @(posedge clock);
    readStrobe <= 1'b0;
    #1 d = rdata;
  endtask

  // Line bits in send order, then parity and stop
  function automatic logic [9:0] lineBits(input logic [7:0] d, input logic inv);
    logic [7:0] v;
    logic [9:0] b;
    v = inv ? ~d : d;
    for (int i = 0; i < 8; i++) begin
      b[i] = inv ? v[7 - i] : v[i];
    end
    b[8] = inv ? ~^b[7:0] : ^b[7:0];
    b[9] = 1'b1;
    return b;
  endfunction

  // Direct: even parity, LSB first, plain; inverse: odd, MSB first, inverted
  task automatic cfg(input logic inv, input logic ere, input logic [7:0] brg);
    regWrite(sim_uart_pkg::REG_BAUD, {8'h00, brg});
    regWrite(sim_uart_pkg::REG_MODE, {10'h000, ~inv, 5'h05});
    regWrite(sim_uart_pkg::REG_CTLA, {8'h00, inv, 7'h00});
    regWrite(sim_uart_pkg::REG_CTLB, {8'h00, ere, inv, 6'h15});
  endtask

  task automatic txCase(input logic inv, input logic [7:0] d, input logic [7:0] brg);
    logic [9:0]  b;
    logic [15:0] v;
    int          len;
    int          w;
    cfg(inv, 1'b1, brg);
    regWrite(sim_uart_pkg::REG_IRQ, 16'h0003);
    @(negedge clock);
    cmpBit(txIrqRequest, 1'b0);
    regWrite(sim_uart_pkg::REG_TXBUF, {8'h00, d});
    card.recvFrame(b, len, 16 * (brg + 1));
    cmp(16'(len), 16'(16 * (brg + 1)));
    cmp({6'h00, b}, {6'h00, lineBits(d, inv)});
    cmpBit(txIrqRequest, 1'b0);
    w = 0;
    while (txIrqRequest !== 1'b1 && w < 16 * (brg + 1)) begin
      @(negedge clock);
      w++;
    end
    cmpBit(txIrqRequest, 1'b1);
    cmpBit(line, 1'b1);
    cmpBit(serialOutPinOut, 1'b0);
    // The block hears its own frame on the shared wire
    regRead(sim_uart_pkg::REG_RXBUF, v);
    cmp(v, {8'h00, d});
  endtask

  task automatic rxCase(input logic inv, input logic [7:0] d, input logic bad,
                        input logic ere);
    logic [9:0]  b;
    logic [15:0] v;
    cfg(inv, ere, 8'h00);
    regWrite(sim_uart_pkg::REG_IRQ, 16'h0003);
    b = lineBits(d, inv);
    b[8] = b[8] ^ bad;
    card.sendFrame(b, 16);
    repeat (4) @(posedge clock);
    cmpBit(rxIrqRequest, 1'b1);
    cmpBit(serialOutPinOe, bad & ere);
    regRead(sim_uart_pkg::REG_RXBUF, v);
    cmp(v, {bad, bad, 6'h00, d});
    repeat (2) @(posedge clock);
    cmpBit(serialOutPinOe, 1'b0);
    if (bad && ere) begin
      regRead(sim_uart_pkg::REG_RXBUF, v);
      cmpBit(v[sim_uart_pkg::RB_PER], 1'b0);
    end
    // The receiver masks the low error pulse and drops its tail at the mid check; wait it out
    repeat (200) @(posedge clock);
    regRead(sim_uart_pkg::REG_RXBUF, v);
  endtask

  task automatic overrunCase();
    logic [15:0] v;
    cfg(1'b0, 1'b1, 8'h00);
    card.sendFrame(lineBits(8'h11, 1'b0), 16);
    regWrite(sim_uart_pkg::REG_IRQ, 16'h0002);
    card.sendFrame(lineBits(8'h22, 1'b0), 16);
    repeat (4) @(posedge clock);
    cmpBit(rxIrqRequest, 1'b0);
    regRead(sim_uart_pkg::REG_RXBUF, v);
    cmp(v & 16'h9000, 16'h9000);
  endtask

  task automatic framingCase();
    logic [9:0]  b;
    logic [15:0] v;
    cfg(1'b0, 1'b1, 8'h00);
    b = lineBits(8'h3C, 1'b0);
    b[9] = 1'b0;
    card.sendFrame(b, 16);
    repeat (20) @(posedge clock);
    regRead(sim_uart_pkg::REG_RXBUF, v);
    cmp(v & 16'hE000, 16'hA000);
  endtask

  initial begin
    logic [15:0] v;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    regRead(3'h7, v);
    cmp(v, 16'h0000);
    txCase(1'b0, 8'hA5, 8'h00);
    txCase(1'b1, 8'h3C, 8'h00);
    txCase(1'b0, 8'h81, 8'h01);
    rxCase(1'b0, 8'h5A, 1'b0, 1'b1);
    rxCase(1'b1, 8'h96, 1'b0, 1'b1);
    rxCase(1'b0, 8'h5A, 1'b1, 1'b1);
    rxCase(1'b1, 8'h0F, 1'b1, 1'b1);
    rxCase(1'b0, 8'h33, 1'b1, 1'b0);
    overrunCase();
    framingCase();
    print_verdict();
  end
endmodule
`default_nettype wire
